/* common/vpump_pkg.sv */
// Contract
// - regulate: stop at threshold, restart below minus 10%
// - parts output on at threshold, hysteresis off
// - vacuum drives both threshold indicator bits
// - sustained mode runs motor continuously at power
// - power 0..255, above 100 is full
// - fieldbus power zero selects local power
// - external blowoff follows blowoff input exactly
// - internal timed blowoff fires on leaving suction
// - blowoff overrides suction request
// - internal timed mode still honours blowoff input
// - external timed pulse fixed, input length ignored
// - blowoff time 0.10 to 9.99 seconds
// - blowoff time hidden in external untimed mode
// - soft start 30 percent ramps to 90
// - output one parts, output two condition monitor
// - outputs selectable open/closed, default open
// - input one suction, input two blowoff
// - inputs default normally open
// - zero calibration only within three percent
// - manual suction toggles, regulation still applies
// - manual blowoff only while button held
// - input change leaves manual mode
package vpump_pkg;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_THR = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PWR = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_BTIME = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_STAT = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_CAL = 5'h14;
    // control register fields
    localparam int CTRL_REG = 0;
    localparam int CTRL_SOFT = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_O1NC = 4;
    localparam int CTRL_O2NC = 5;
    localparam int CTRL_I1NC = 6;
    localparam int CTRL_I2NC = 7;
    localparam logic [1:0] BLOW_EXT = 2'h0;
    localparam logic [1:0] BLOW_INT = 2'h1;
    localparam logic [1:0] BLOW_ETM = 2'h2;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [7:0] CTHR_RST = 8'h60;
    localparam logic [7:0] PTHR_RST = 8'h80;
    localparam logic [7:0] PHYS_RST = 8'h05;
    localparam logic [7:0] PWR_RST = 8'h64;
    localparam logic [9:0] BTIME_RST = 10'h014;
    localparam logic [9:0] BTIME_MIN = 10'h00A;
    localparam logic [9:0] BTIME_MAX = 10'h3E7;
    localparam logic [7:0] FULL_PWR = 8'h64;
    localparam int CAL_PCT = 3;
    localparam logic [7:0] CAL_LIMIT = 8'((255 * CAL_PCT) / 100);
    localparam logic [6:0] SOFT_START_PCT = 7'h1E;
    localparam logic [6:0] SOFT_END_PCT = 7'h5A;
    localparam int CLK_MHZ = 125;
    localparam int TICK_MS = 10;
    localparam int SOFT_RAMP_MS = 400;
    localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    localparam int RAMP_STEP_CYCLES = SOFT_RAMP_MS * 1000 * CLK_MHZ / (90 - 30);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hdl/vacuum_pump_control_logic.sv */
`timescale 1ns/1ns
module vacuum_pump_control_logic #(
    parameter int TICK_CYC = vpump_pkg::TICK_CYCLES,
    parameter int RAMP_CYC = vpump_pkg::RAMP_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [vpump_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [vpump_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] vacuum_level,
    input wire logic [7:0] bus_power,
    input wire logic suction_input,
    input wire logic blowoff_input,
    input wire logic cm_active,
    input wire logic btn_manual_enter,
    input wire logic btn_manual_exit,
    input wire logic btn_suction,
    input wire logic btn_blowoff,
    output logic pump_on,
    output logic [6:0] motor_power,
    output logic blowoff_valve,
    output logic parts_present_output,
    output logic condition_monitor_output,
    output logic control_indicator,
    output logic parts_indicator,
    output logic manual_mode,
    output logic cal_error,
    output logic blow_time_visible
);
    import vpump_pkg::*;

    localparam int TW = $clog2(TICK_CYC + 1);
    localparam int RW = $clog2(RAMP_CYC + 1);

    if (TICK_CYC < 2 || RAMP_CYC < 2) begin : g_chk
        $error("tick and ramp counts must be at least 2");
    end

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cthr;
        logic [7:0] pthr;
        logic [7:0] phys;
        logic [7:0] pwr;
        logic [9:0] btime;
        logic [7:0] offset;
        logic cal_err;
        logic aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic in1_q;
        logic in2_q;
        logic suct_q;
        logic manual;
        logic man_suct;
        logic hold;
        logic ctrl_ind;
        logic parts_ind;
        logic [9:0] blow_cnt;
        logic [TW-1:0] tick_cnt;
        logic ramping;
        logic [6:0] ramp_pct;
        logic [RW-1:0] ramp_cnt;
        logic pump;
        logic valve;
        logic [6:0] mpwr;
        logic out_pp;
        logic out_cm;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // saturating subtract, used for offset and both lower thresholds
    function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? 8'(a - b) : 8'h00;
    endfunction

    // byte-lane merge for AXI write strobes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic [7:0] vac;
    logic in1_eff;
    logic in2_eff;
    logic [1:0] mode;
    logic [7:0] tgt;
    logic [6:0] pct;
    logic tick;

    ////////////////////////////////////////////////////////////////////////
    // derived values from the registered state
    always_comb begin
        vac = sat_sub(vacuum_level, s_r.offset);
        in1_eff = suction_input ^ s_r.ctrl[CTRL_I1NC];
        in2_eff = blowoff_input ^ s_r.ctrl[CTRL_I2NC];
        mode = s_r.ctrl[CTRL_MODE +: 2];
        tgt = (bus_power != 8'h00) ? bus_power : s_r.pwr;
        pct = (tgt > FULL_PWR) ? FULL_PWR[6:0] : tgt[6:0];
        tick = (s_r.tick_cnt == TW'(TICK_CYC - 1));
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: bus slave, then control path
    always_comb begin
        logic [31:0] wv;
        logic suct_req;
        logic blow_req;
        logic load;
        logic pump_go;
        wv = 32'h0000_0000;
        suct_req = 1'b0;
        blow_req = 1'b0;
        load = 1'b0;
        pump_go = 1'b0;
        s_nxt = s_r;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_got && s_r.w_got) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            case (s_r.awaddr)
                OFS_CTRL: begin
                    wv = merge({24'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb);
                    s_nxt.ctrl = wv[7:0];
                end
                OFS_THR: begin
                    wv = merge({8'h0, s_r.phys, s_r.pthr, s_r.cthr}, s_r.wdata, s_r.wstrb);
                    s_nxt.cthr = wv[7:0];
                    s_nxt.pthr = wv[15:8];
                    s_nxt.phys = wv[23:16];
                end
                OFS_PWR: begin
                    wv = merge({24'h0, s_r.pwr}, s_r.wdata, s_r.wstrb);
                    s_nxt.pwr = wv[7:0];
                end
                OFS_BTIME: begin
                    wv = merge({22'h0, s_r.btime}, s_r.wdata, s_r.wstrb);
                    // out-of-range times clamp rather than fault
                    if (wv[9:0] < BTIME_MIN) begin
                        s_nxt.btime = BTIME_MIN;
                    end else if (wv[9:0] > BTIME_MAX) begin
                        s_nxt.btime = BTIME_MAX;
                    end else begin
                        s_nxt.btime = wv[9:0];
                    end
                end
                OFS_STAT: begin
                end
                OFS_CAL: begin
                    if (s_r.wstrb[0] && s_r.wdata[0]) begin
                        // sensor must sit at atmosphere when this is issued
                        if (vacuum_level <= CAL_LIMIT) begin
                            s_nxt.offset = vacuum_level;
                            s_nxt.cal_err = 1'b0;
                        end else begin
                            s_nxt.cal_err = 1'b1;
                        end
                    end
                end
                default: s_nxt.bresp = RESP_SLVERR;
            endcase
        end

        // read channel: one outstanding read, data held until taken
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            case (s_axi_araddr)
                OFS_CTRL: s_nxt.rdata = {24'h0, s_r.ctrl};
                OFS_THR: s_nxt.rdata = {8'h0, s_r.phys, s_r.pthr, s_r.cthr};
                OFS_PWR: s_nxt.rdata = {24'h0, s_r.pwr};
                OFS_BTIME: s_nxt.rdata = {22'h0, s_r.btime};
                OFS_STAT: s_nxt.rdata = {16'h0, 1'b0, s_r.mpwr, 1'b0, (mode != BLOW_EXT),
                                         s_r.cal_err, s_r.manual, s_r.valve, s_r.pump,
                                         s_r.parts_ind, s_r.ctrl_ind};
                OFS_CAL: s_nxt.rdata = {16'h0, s_r.offset, 7'h0, s_r.cal_err};
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                    s_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end

        // manual mode entry and exit
        s_nxt.in1_q = suction_input;
        s_nxt.in2_q = blowoff_input;
        if (btn_manual_enter) begin
            s_nxt.manual = 1'b1;
            s_nxt.man_suct = 1'b0;
        end
        if (btn_manual_exit || suction_input != s_r.in1_q || blowoff_input != s_r.in2_q) begin
            s_nxt.manual = 1'b0;
        end
        if (s_r.manual && btn_suction) begin
            s_nxt.man_suct = !s_r.man_suct;
        end else if (s_r.manual && btn_blowoff) begin
            s_nxt.man_suct = 1'b0;
        end
        suct_req = s_r.manual ? s_r.man_suct : in1_eff;
        s_nxt.suct_q = suct_req;
        // blowoff timer: 10 ms tick, restarted so a pulse is whole ticks
        s_nxt.tick_cnt = tick ? '0 : TW'(s_r.tick_cnt + 1'b1);
        if (tick && s_r.blow_cnt != 10'h000) begin
            s_nxt.blow_cnt = 10'(s_r.blow_cnt - 1'b1);
        end
        if (!s_r.manual) begin
            if (mode == BLOW_INT && s_r.suct_q && !suct_req) begin
                load = 1'b1;
            end
            if (mode == BLOW_ETM && in2_eff && !(s_r.in2_q ^ s_r.ctrl[CTRL_I2NC])) begin
                load = 1'b1;
            end
        end
        if (load) begin
            s_nxt.blow_cnt = s_r.btime;
            s_nxt.tick_cnt = '0;
        end
        // valve source per mode
        if (s_r.manual) begin
            blow_req = btn_blowoff;
        end else begin
            case (mode)
                BLOW_EXT: blow_req = in2_eff;
                BLOW_INT: blow_req = in2_eff || s_nxt.blow_cnt != 10'h000;
                BLOW_ETM: blow_req = s_nxt.blow_cnt != 10'h000;
                default: blow_req = in2_eff;
            endcase
        end
        s_nxt.valve = blow_req;
        // thresholds; indicator states feed status and process bits
        s_nxt.ctrl_ind = vac >= s_r.cthr;
        if (vac >= s_r.cthr) begin
            s_nxt.hold = 1'b1;
        end else if (vac < sat_sub(s_r.cthr, s_r.cthr / 8'h0A)) begin
            s_nxt.hold = 1'b0;
        end
        if (vac >= s_r.pthr) begin
            s_nxt.parts_ind = 1'b1;
        end else if (vac < sat_sub(s_r.pthr, s_r.phys)) begin
            s_nxt.parts_ind = 1'b0;
        end
        // pump: blowoff wins, regulation only when enabled
        pump_go = suct_req && !blow_req;
        if (s_r.ctrl[CTRL_REG] && s_nxt.hold) begin
            pump_go = 1'b0;
        end
        s_nxt.pump = pump_go;
        // soft start ramp, restarted at every motor start
        if (pump_go && !s_r.pump && s_r.ctrl[CTRL_SOFT]) begin
            s_nxt.ramping = 1'b1;
            s_nxt.ramp_pct = SOFT_START_PCT;
            s_nxt.ramp_cnt = '0;
        end else if (s_r.ramping) begin
            s_nxt.ramp_cnt = RW'(s_r.ramp_cnt + 1'b1);
            if (s_r.ramp_cnt == RW'(RAMP_CYC - 1)) begin
                s_nxt.ramp_cnt = '0;
                s_nxt.ramp_pct = 7'(s_r.ramp_pct + 1'b1);
                if (s_r.ramp_pct + 7'h01 >= SOFT_END_PCT) begin
                    s_nxt.ramping = 1'b0;
                end
            end
        end
        if (!pump_go) begin
            s_nxt.ramping = 1'b0;
            s_nxt.mpwr = 7'h00;
        end else if (s_nxt.ramping && s_nxt.ramp_pct < pct) begin
            s_nxt.mpwr = s_nxt.ramp_pct;
        end else begin
            s_nxt.mpwr = pct;
        end

        // output polarity: closed contacts invert the function level
        s_nxt.out_pp = s_nxt.parts_ind ^ s_nxt.ctrl[CTRL_O1NC];
        s_nxt.out_cm = cm_active ^ s_nxt.ctrl[CTRL_O2NC];
    end

    ////////////////////////////////////////////////////////////////////////
    // single state register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.cthr <= CTHR_RST;
            s_r.pthr <= PTHR_RST;
            s_r.phys <= PHYS_RST;
            s_r.pwr <= PWR_RST;
            s_r.btime <= BTIME_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign pump_on = s_r.pump;
    assign motor_power = s_r.mpwr;
    assign blowoff_valve = s_r.valve;
    assign parts_present_output = s_r.out_pp;
    assign condition_monitor_output = s_r.out_cm;
    assign control_indicator = s_r.ctrl_ind;
    assign parts_indicator = s_r.parts_ind;
    assign manual_mode = s_r.manual;
    assign cal_error = s_r.cal_err;
    // menu shows the time in every mode except external untimed
    assign blow_time_visible = (mode != BLOW_EXT);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_etm_trig;
        !s_r.manual && mode == BLOW_ETM && $rose(in2_eff) && s_r.blow_cnt == 10'h000;
    endsequence

    sequence seq_timer_last;
        s_r.valve && s_r.blow_cnt == 10'h001 && tick;
    endsequence

    AST_REG_STOP: assert property (s_r.ctrl[CTRL_REG] && vac >= s_r.cthr |=> !s_r.pump)
        else $error("pump ran at control threshold");
    AST_PARTS_ON: assert property (vac >= s_r.pthr |=> s_r.parts_ind)
        else $error("parts indicator missed threshold");
    AST_EXT_BLOW: assert property (!s_r.manual && mode == BLOW_EXT && !btn_manual_enter
        |=> s_r.valve == $past(in2_eff))
        else $error("external blowoff not following input");
    AST_PRIO: assert property (s_r.valve |-> !s_r.pump)
        else $error("pump on during blowoff");
    AST_ETM_LOAD: assert property (seq_etm_trig |=> s_r.valve && s_r.blow_cnt == $past(s_r.btime))
        else $error("timed pulse not started with set time");
    AST_ETM_END: assert property (seq_timer_last and (mode == BLOW_ETM && !s_r.manual
        && !$rose(in2_eff)) |=> !s_r.valve)
        else $error("timed pulse outlived its time");
    AST_PWR_CLAMP: assert property (!s_r.ramping |-> s_r.mpwr <= FULL_PWR[6:0])
        else $error("motor power above full");
    AST_SOFT: assert property ($rose(s_r.pump) && s_r.ctrl[CTRL_SOFT]
        |-> s_r.mpwr <= SOFT_START_PCT ##1 s_r.mpwr <= SOFT_START_PCT)
        else $error("soft start began too high");
    AST_MAN_EXIT: assert property (suction_input != $past(suction_input) |=> !s_r.manual)
        else $error("manual mode kept after input change");
    AST_BTIME: assert property (s_r.btime >= BTIME_MIN && s_r.btime <= BTIME_MAX)
        else $error("blowoff time out of range");
endmodule

/* tb/sys_ctrl_model.sv */
`timescale 1ns/1ns
module sys_ctrl_model (
    input wire logic core_clk,
    input wire logic want_suction,
    input wire logic want_blowoff,
    input wire logic in1_nc,
    input wire logic in2_nc,
    output logic suction_input,
    output logic blowoff_input
);
    // pins idle at the released level until the first edge
    initial suction_input = 1'b0;
    initial blowoff_input = 1'b0;
    // pins follow a request one edge later, like a real output stage
    always @(posedge core_clk) begin
        suction_input <= want_suction ^ in1_nc;
        blowoff_input <= want_blowoff ^ in2_nc;
    end
endmodule

/* tb/vacuum_pump_control_logic_tb_top.sv */
`timescale 1ns/1ns
module vacuum_pump_control_logic_tb_top;
    import vpump_pkg::*;
    `define CHECK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
        $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
    note_t wq[$];
    note_t rq[$];
    note_t e;
    int mismatches = 0;
    int check_count = 0;
    int seed = 32'hbca55789;
    int n;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] vac = 8'h00, bus_pwr = 8'h00, p;
    logic [6:0] e7;
    logic want_s = 1'b0, want_b = 1'b0, nc1 = 1'b0, nc2 = 1'b0, cm = 1'b0;
    logic b_enter = 1'b0, b_suck = 1'b0, b_blow = 1'b0;
    logic s_in, b_in, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic pump, valve, ppo, cmo, cind, pind, man, cerr, vis;
    logic [6:0] mpow;
    logic [31:0] rv [6] = '{32'h01, 32'h00058060, 32'h64, 32'h14, 32'h0, 32'h0};
    logic [7:0] pv [5] = '{8'h00, 8'h32, 8'h64, 8'h65, 8'hFF};

    always #4 core_clk = ~core_clk;

    // short tick and ramp so timed behaviour fits a short run
    vacuum_pump_control_logic #(.TICK_CYC(20), .RAMP_CYC(4)) vacuum_pump_control_logic_i (
        .core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .vacuum_level(vac), .bus_power(bus_pwr), .suction_input(s_in), .blowoff_input(b_in),
        .cm_active(cm), .btn_manual_enter(b_enter), .btn_manual_exit(1'b0),
        .btn_suction(b_suck), .btn_blowoff(b_blow), .pump_on(pump), .motor_power(mpow),
        .blowoff_valve(valve), .parts_present_output(ppo), .condition_monitor_output(cmo),
        .control_indicator(cind), .parts_indicator(pind), .manual_mode(man),
        .cal_error(cerr), .blow_time_visible(vis));

    sys_ctrl_model sys_ctrl_model_i (.core_clk(core_clk), .want_suction(want_s),
        .want_blowoff(want_b), .in1_nc(nc1), .in2_nc(nc2), .suction_input(s_in),
        .blowoff_input(b_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask

    // handshakes sampled at the falling edge, where ready is settled for the next rise
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        int k = 0;
        logic ta, tw, tb;
        @(posedge core_clk);
        wq.push_back('{d: 32'h0, m: 32'h0, r: r});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            k++;
            if (k > 200) begin mismatches++; report_and_stop(); end
        end while (!tb);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        int k = 0;
        logic ta, tr;
        @(posedge core_clk);
        rq.push_back('{d: d & m, m: m, r: r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            k++;
            if (k > 200) begin mismatches++; report_and_stop(); end
        end while (!tr);
    endtask

    task automatic stat(input logic [31:0] d, input logic [31:0] m);
        rd(OFS_STAT, d, m, RESP_OKAY);
    endtask

    task automatic vstat(input logic [7:0] v, input logic [31:0] d, input logic [31:0] m);
        vac <= v;
        cyc(4);
        stat(d, m);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // oldest note is matched against each answer as it appears
    always @(negedge core_clk) begin
        if (bvalid && bready) begin
            e = wq.pop_front();
            `CHECK(bresp, e.r)
        end
        if (rvalid && rready) begin
            e = rq.pop_front();
            `CHECK(rresp, e.r)
            `CHECK(rdata & e.m, e.d)
        end
    end

    // hang guard
    initial begin
        cyc(20000);
        mismatches++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(6);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rd(5'(4 * i), rv[i], 32'hFFFFFFFF, RESP_OKAY);
        rd(5'h18, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wr(5'h1C, 32'h0, RESP_SLVERR);
        wr(OFS_STAT, 32'hFF, RESP_OKAY);
        $display("test reset done");
        want_s <= 1'b1;
        cm <= 1'b1;
        vstat(8'h00, 32'h4, 32'h5);
        vstat(8'h60, 32'h1, 32'h5);
        vstat(8'h57, 32'h0, 32'h5);
        vstat(8'h56, 32'h4, 32'h5);
        vstat(8'h80, 32'h2, 32'h2);
        `CHECK(pind, 1'b1)
        `CHECK(cind, 1'b1)
        `CHECK(ppo, 1'b1)
        `CHECK(cmo, 1'b1)
        vstat(8'h7B, 32'h2, 32'h2);
        vstat(8'h7A, 32'h0, 32'h2);
        `CHECK(ppo, 1'b0)
        $display("test thresholds done");
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            p = (i < 5) ? pv[i] : 8'($random(seed));
            bus_pwr <= p;
            e7 = (p == 8'h00 || p > 8'h64) ? 7'h64 : p[6:0];
            cyc(3);
            stat({17'h0, e7, 8'h04}, 32'h7F04);
        end
        wr(OFS_PWR, 32'h1E, RESP_OKAY);
        bus_pwr <= 8'h00;
        cyc(3);
        stat(32'h1E04, 32'h7F04);
        `CHECK(pump, 1'b1)
        wr(OFS_PWR, 32'h64, RESP_OKAY);
        wr(OFS_CTRL, 32'h2, RESP_OKAY);
        want_s <= 1'b0;
        cyc(4);
        want_s <= 1'b1;
        n = 0;
        while (!pump && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (!pump) begin mismatches++; report_and_stop(); end
        `CHECK(mpow, 7'h1E)
        // mid-ramp: 30 steps of four cycles above the start level
        cyc(120);
        stat(32'h3C04, 32'h7F04);
        cyc(180);
        stat(32'h6404, 32'h7F04);
        $display("test power done");
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        want_b <= 1'b1;
        cyc(4);
        stat(32'h8, 32'h4C);
        want_b <= 1'b0;
        cyc(4);
        stat(32'h4, 32'h4C);
        wr(OFS_BTIME, 32'h5, RESP_OKAY);
        rd(OFS_BTIME, 32'h00A, 32'h3FF, RESP_OKAY);
        wr(OFS_CTRL, 32'h4, RESP_OKAY);
        cyc(4);
        want_s <= 1'b0;
        cyc(100);
        stat(32'h48, 32'h4C);
        cyc(120);
        stat(32'h40, 32'h48);
        want_b <= 1'b1;
        cyc(4);
        stat(32'h8, 32'h8);
        want_b <= 1'b0;
        cyc(250);
        // a long press must not stretch the timed pulse
        wr(OFS_CTRL, 32'h8, RESP_OKAY);
        want_b <= 1'b1;
        cyc(100);
        stat(32'h48, 32'h48);
        `CHECK(vis, 1'b1)
        `CHECK(valve, 1'b1)
        cyc(120);
        stat(32'h40, 32'h48);
        want_b <= 1'b0;
        wr(OFS_BTIME, 32'h3FF, RESP_OKAY);
        rd(OFS_BTIME, 32'h3E7, 32'h3FF, RESP_OKAY);
        $display("test blowoff done");
        wr(OFS_CTRL, 32'h30, RESP_OKAY);
        vac <= 8'h00;
        cyc(4);
        `CHECK(ppo, 1'b1)
        `CHECK(vis, 1'b0)
        `CHECK(cmo, 1'b0)
        cm <= 1'b0;
        cyc(4);
        `CHECK(cmo, 1'b1)
        want_s <= 1'b1;
        wr(OFS_CTRL, 32'hC0, RESP_OKAY);
        nc1 <= 1'b1;
        nc2 <= 1'b1;
        cyc(4);
        stat(32'h4, 32'hC);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        nc1 <= 1'b0;
        nc2 <= 1'b0;
        $display("test polarity done");
        vac <= 8'h07;
        wr(OFS_CAL, 32'h1, RESP_OKAY);
        rd(OFS_CAL, 32'h0700, 32'hFF01, RESP_OKAY);
        vac <= 8'h08;
        wr(OFS_CAL, 32'h1, RESP_OKAY);
        rd(OFS_CAL, 32'h1, 32'h1, RESP_OKAY);
        stat(32'h20, 32'h20);
        `CHECK(cerr, 1'b1)
        $display("test calibration done");
        want_s <= 1'b0;
        vac <= 8'h00;
        cyc(4);
        b_enter <= 1'b1;
        cyc(1);
        b_enter <= 1'b0;
        cyc(3);
        stat(32'h10, 32'h14);
        `CHECK(man, 1'b1)
        b_suck <= 1'b1;
        cyc(1);
        b_suck <= 1'b0;
        cyc(3);
        stat(32'h14, 32'h1C);
        b_blow <= 1'b1;
        cyc(3);
        stat(32'h18, 32'h1C);
        b_blow <= 1'b0;
        cyc(3);
        stat(32'h10, 32'h1C);
        want_s <= 1'b1;
        cyc(4);
        stat(32'h4, 32'h14);
        `CHECK(man, 1'b0)
        $display("test manual done");
        report_and_stop();
    end
endmodule
